// [bench/mpdu_assembler_properties.sv]
// Port checker for the MPDU assembler
`timescale 1ns/1ps
module mpdu_assembler_properties
  import mpdu_pkg::*;
(
  input wire logic clk, rst_n, lpduReady, mpduDone, rtsReq, ctsOk, rxValid,
  input wire logic [7:0] rxData,
  input wire logic [2:0] mpduPrio,
  input wire byte_beat_t txOut, lcduOut, rxLpdu
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [10:0] lcCnt_q;
  // Octets of the current LCDU before this one
  always_ff @(posedge clk) begin
    if (!rst_n) lcCnt_q <= 11'h000;
    else if (lcduOut.valid) lcCnt_q <= lcduOut.first ? 11'h001 : lcCnt_q + 11'h001;
  end
  a_prio_hold: assert property (!mpduDone |-> $stable(mpduPrio)) else $error("prio moved");
  a_done_follows: assert property (txOut.valid && txOut.last |-> mpduDone ##1 (!txOut.valid && !mpduDone))
    else $error("no done");
  a_mpdu_single: assert property (mpduDone |=> !mpduDone) else $error("done held");
  a_cts_gate: assert property (rtsReq ##1 !ctsOk |-> !lpduReady) else $error("sent before CTS");
  a_first_octet: assert property (txOut.first |-> txOut.valid && !$past(txOut.valid)) else $error("bad first");
  a_lcdu_hdr_run: assert property (lcduOut.valid && lcduOut.first |=> lcduOut.valid [*8]) else $error("gap");
  a_lcdu_min_len: assert property (lcduOut.valid && lcduOut.last |-> lcCnt_q >= 11'h03B) else $error("short");
  a_rx_pass: assert property (rxValid |=> rxLpdu.valid && rxLpdu.data == $past(rxData)) else $error("rx lost");
  c_mgmt: cover property (mpduDone && mpduPrio == MGMT_PRIO);
  c_rts: cover property (rtsReq ##[1:20] lpduReady);
  c_lcdu: cover property (lcduOut.valid && lcduOut.last);
endmodule
bind mpdu_assembler mpdu_assembler_properties mpdu_assembler_properties_inst (.clk, .rst_n, .lpduReady,
  .mpduDone, .rtsReq, .ctsOk, .rxValid, .rxData, .mpduPrio, .txOut, .lcduOut, .rxLpdu);

// [bench/mpdu_assembler_tb_top.sv]
// Self-checking bench for the MPDU assembler
`timescale 1ns/1ps
module mpdu_assembler_tb_top;
  import mpdu_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lpduValid = 0, lpduLast = 0, err;
  logic payValid = 0, payLast = 0, rxValid = 0, rxLast = 0, pready, pslverr, lpduReady, mpduDone;
  logic spareReq, spareValid, rtsReq, ctsOk, payReady;
  logic [7:0] paddr = 0, lpduData = 0, payData = 0, rxData = 0, seen[$], lc[$];
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] spareBits, spareCfg = 0, s;
  logic [63:0] d;
  logic [31:0] f;
  logic [9:0] rq[$];
  logic [2:0] mpduPrio;
  lpdu_meta_t lpduMeta = '0;
  byte_beat_t txOut, lcduOut, rxLpdu;
  int n_errors = 0, n_checks = 0, exp[$], sp[4] = '{200, 0, 96, 0}, z[$] = '{0, 0, 0, 0, 0, 0, 0, 0};
  lpdu_meta_t cs[4][2] = '{'{'{1, 0, 0, 1, 1, 0, 0}, '{0, 0, 0, 0, 5, 0, 1}},
    '{'{0, 1, 0, 0, 2, 0, 0}, '{0, 1, 0, 0, 4, 0, 1}}, '{'{0, 0, 1, 0, 6, 1, 0}, '{0, 0, 1, 0, 3, 1, 1}},
    '{'{0, 1, 0, 0, 0, 0, 0}, '{0, 0, 0, 1, 2, 0, 1}}};
  always #5 clk = ~clk;
  mpdu_assembler mpdu_assembler_inst (.*);
  phy_model phy_model_inst (.clk, .rst_n, .spareReq, .rtsReq, .spareCfg, .spareValid, .ctsOk, .spareBits);
  always @(posedge clk) begin
    if (txOut.valid) seen.push_back(txOut.data);
    if (lcduOut.valid) lc.push_back(lcduOut.data);
    if (rxLpdu.valid) rq.push_back({rxLpdu.first, rxLpdu.last, rxLpdu.data});
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, want);
    n_checks++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmpq(input logic [7:0] q[$]);
    check(q.size(), exp.size());
    foreach (exp[i]) if (exp[i] >= 0) check(q[i], exp[i]);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // Resent LPDUs arrive with the old OPSF so the change must show
  task automatic send(input lpdu_meta_t m, input logic [15:0] n);
    logic [7:0] b, e;
    int h[$];
    lpduMeta <= m;
    for (int i = 0; i < 8; i++) begin
      b = i < 2 ? n[8*i+:8] : i == 2 ? 8'h00 : i == 3 ? {3'h0, m.newOpsf ^ m.resent, m.mgmt, 3'h4} : 8'($urandom);
      e = i == 3 ? {3'h0, m.newOpsf, m.mgmt, 3'h4} : b;
      if (i < 4) h.push_back(e);
      exp.push_back(i > 3 && m.resent ? 8'(crc(h, LPCS_POLY) >> 8 * (i - 4)) : e);
      lpduValid <= 1;
      lpduData <= b;
      lpduLast <= i == 7;
      do @(posedge clk); while (!lpduReady);
    end
  endtask
  // Reflected CRC, low bit of each octet first, returned inverted
  function automatic logic [31:0] crc(input int q[$], input logic [31:0] poly);
    logic [31:0] c = CRC_INIT;
    foreach (q[i]) for (int j = 0; j < 8; j++) c = (c[0] ^ q[i][j]) ? (c >> 1) ^ poly : c >> 1;
    return ~c;
  endfunction
  function automatic int prio_of(input lpdu_meta_t m[2]);
    lpdu_meta_t q[$];
    int k = 0, p = 7;
    foreach (m[i]) if (!m[i].mgmt && !m[i].resent) q.push_back(m[i]);
    if (q.size() == 0) foreach (m[i]) if (!m[i].mgmt) q.push_back(m[i]);
    if (q.size() == 0) return 7;
    while (k < q.size() && q[k].trailing) k++;
    if (k == q.size()) return q[0].lpri;
    for (int i = k; i < q.size(); i++) if (q[i].lpri < p) p = q[i].lpri;
    return p;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(22524));
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, REG_LEN, 0);
    check(rd, 32'h48);
    apb(0, 8'h20, 0);
    check(err, 1'b1);
    apb(1, REG_LEN, 32'hC);
    for (int c = 0; c < 4; c++) begin
      if (c == 3) apb(1, REG_CTRL, 32'h2);
      s = c == 0 ? 16'hFFFF : 16'($urandom);
      spareCfg <= 16'(sp[c]);
      exp = {};
      seen = {};
      send(cs[c][0], s);
      send(cs[c][1], s + 16'h1);
      lpduValid <= 0;
      f = crc(z, LPCS_POLY);
      for (int r = sp[c]; r > 96; r -= 96) begin
        for (int j = 0; j < 12; j++) exp.push_back(j < 8 ? 0 : 8'(f >> 8 * (j - 8)));
      end
      for (int t = 0; t < 400 && !mpduDone; t++) @(posedge clk);
      check(mpduDone, 1'b1);
      check(mpduPrio, prio_of(cs[c]));
      @(posedge clk);
      cmpq(seen);
      $display("mpdu case %0d done", c);
    end
    for (int mic = 0; mic < 2; mic++) begin
      d = {$urandom, $urandom};
      apb(1, REG_CTRL, mic);
      apb(1, REG_DA_LO, d[31:0]);
      apb(1, REG_DA_HI, d[63:32]);
      apb(1, REG_SA_LO, ~d[31:0]);
      apb(1, REG_SA_HI, ~d[63:32]);
      exp = {};
      lc = {};
      for (int i = 0; i < 12; i++) exp.push_back(i < 6 ? d[8*i+:8] : ~d[8*i-48+:8]);
      exp = {exp, 8'h22, 8'hE3};
      for (int i = 0; i < 6; i++) begin
        payValid <= 1;
        payData <= 8'($urandom);
        payLast <= i == 5;
        do @(posedge clk); while (!payReady);
        exp.push_back(payData);
      end
      payValid <= 0;
      while (exp.size() < 60) exp.push_back(0);
      f = crc(exp, FCS_POLY);
      if (mic == 0) for (int j = 0; j < 4; j++) exp.push_back(f[8*j+:8]);
      for (int t = 0; t < 400 && lc.size() < exp.size(); t++) @(posedge clk);
      repeat (3) @(posedge clk);
      cmpq(lc);
      $display("lcdu case %0d done", mic);
    end
    apb(0, REG_STAT, 0);
    check(rd[2:0], 3'h0);
    exp = {};
    for (int i = 0; i < 5; i++) begin
      rxValid <= 1;
      rxData <= 8'($urandom);
      rxLast <= i == 4;
      @(posedge clk);
      exp.push_back({i == 0, i == 4, rxData});
    end
    rxValid <= 0;
    repeat (4) @(posedge clk);
    check(rq.size(), 5);
    foreach (exp[i]) check(rq[i], exp[i]);
    final_report();
  end
endmodule

// [bench/phy_model.sv]
// PHY-side model answering spare-capacity and RTS requests
`timescale 1ns/1ps
module phy_model (
  input wire logic clk, rst_n, spareReq, rtsReq,
  input wire logic [15:0] spareCfg,
  output logic spareValid, ctsOk,
  output logic [15:0] spareBits
);
  logic [3:0] spDly_q, ctsDly_q;
  // Late answers so the design must really wait
  always_ff @(posedge clk) begin
    spDly_q <= !rst_n ? 4'h0 : spareReq ? 4'h3 : spDly_q - {3'h0, spDly_q != 4'h0};
    ctsDly_q <= !rst_n ? 4'h0 : rtsReq ? 4'h5 : ctsDly_q - {3'h0, ctsDly_q != 4'h0};
  end
  assign spareValid = spDly_q == 4'h1;
  assign ctsOk = ctsDly_q == 4'h1;
  // Stale bits are inverted so a late sample is caught
  assign spareBits = spareValid ? spareCfg : ~spareCfg;
endmodule

// [verilog/mpdu_assembler.sv]
// MPDU assembler: LPDU concatenation, padding, priority, LCDU formatting and receive split
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mpdu_assembler
  import mpdu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // LPDU stream from the LLC
  input wire logic lpduValid,
  input wire logic [7:0] lpduData,
  input wire logic lpduLast,
  input wire lpdu_meta_t lpduMeta,
  output logic lpduReady,
  // MPDU stream to the PHY
  output byte_beat_t txOut,
  output logic [2:0] mpduPrio,
  output logic mpduDone,
  output logic spareReq,
  input wire logic spareValid,
  input wire logic [15:0] spareBits,
  output logic rtsReq,
  input wire logic ctsOk,
  // Management LCDU payload in, formatted LCDU out
  input wire logic payValid,
  input wire logic [7:0] payData,
  input wire logic payLast,
  output logic payReady,
  output byte_beat_t lcduOut,
  // Receive direction
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  output byte_beat_t rxLpdu
);

  typedef enum logic [2:0] {T_IDLE, T_CTS, T_BODY, T_SPARE, T_FLUSH, T_PAD} tx_state_t;
  typedef enum logic [2:0] {L_IDLE, L_HDR, L_PAY, L_PAD, L_FCS} lc_state_t;

  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d, input logic [31:0] poly);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ poly) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] ctrl_q;
  logic [15:0] lpduLen_q;
  logic [31:0] daLo_q, saLo_q;
  logic [15:0] daHi_q, saHi_q;
  logic [2:0] err_q, errSet, errClr;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [31:0] rdMux;
  logic hit, wrEn;

  tx_state_t txState_q;
  lc_state_t lcState_q;
  logic lpduReady_q, rtsReq_q, spareReq_q, mpduDone_q, firstOut_q, chg_q, padMore_q;
  logic [15:0] idx_q;
  logic [1:0] cnt_q;
  logic [31:0] crc_q;
  logic [18:0] spareRem_q;
  logic [7:0] dly_q [4];
  lpdu_meta_t meta_q;
  logic [2:0] mpduPrio_q;
  byte_beat_t txOut_q;

  always_comb begin
    hit = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rdMux = {30'h0, ctrl_q};
      REG_LEN: rdMux = {16'h0000, lpduLen_q};
      REG_DA_LO: rdMux = daLo_q;
      REG_DA_HI: rdMux = {16'h0000, daHi_q};
      REG_SA_LO: rdMux = saLo_q;
      REG_SA_HI: rdMux = {16'h0000, saHi_q};
      REG_STAT: begin
        rdMux[2:0] = err_q;
        rdMux[STAT_TXBUSY] = txState_q != T_IDLE;
        rdMux[STAT_LCBUSY] = lcState_q != L_IDLE;
      end
      REG_PRIO: rdMux = {29'h0, mpduPrio_q};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: the answer is registered, so pready comes one cycle into the access phase
  assign wrEn = psel && penable && pready_q && pwrite && hit;
  assign errClr = (wrEn && paddr == REG_STAT) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      if (psel && penable && !pready_q) begin
        prdata_q <= (hit && !pwrite) ? rdMux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      lpduLen_q <= LPDU_LEN_RST;
      daLo_q <= 32'h0000_0000;
      daHi_q <= 16'h0000;
      saLo_q <= 32'h0000_0000;
      saHi_q <= 16'h0000;
    end else if (wrEn) begin
      case (paddr)
        REG_CTRL: ctrl_q <= pwdata[1:0];
        REG_LEN: lpduLen_q <= pwdata[15:0];
        REG_DA_LO: daLo_q <= pwdata;
        REG_DA_HI: daHi_q <= pwdata[15:0];
        REG_SA_LO: saLo_q <= pwdata;
        REG_SA_HI: saHi_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Sticky error flags; a new event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_q <= 3'h0;
    end else begin
      err_q <= (err_q & ~errClr) | errSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  logic accept, firstAcc, mpduStart;
  logic [18:0] lpduBits;
  logic [31:0] crcOut;
  logic [7:0] byteIn;
  logic [2:0] prioCalc;

  assign accept = lpduValid && lpduReady_q;
  assign firstAcc = accept && idx_q == 16'h0000;
  assign mpduStart = txState_q == T_IDLE && lpduValid;
  assign lpduBits = {lpduLen_q, 3'b000};
  assign crcOut = ~crc_q;
  // Only the OPSF bit of a resent LPDU may be rewritten
  assign byteIn = (idx_q == FLAG_OCTET && meta_q.resent) ?
                  {lpduData[7:OPSF_BIT+1], meta_q.newOpsf, lpduData[OPSF_BIT-1:0]} : lpduData;

  // Four-octet delay so the trailing LPCS can be swapped before it leaves
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        dly_q[i] <= 8'h00;
      end
    end else if ((txState_q == T_BODY && accept) || txState_q == T_FLUSH) begin
      dly_q[0] <= (txState_q == T_BODY) ? byteIn : 8'h00;
      for (int i = 1; i < 4; i++) begin
        dly_q[i] <= dly_q[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txState_q <= T_IDLE;
      lpduReady_q <= 1'b0;
      txOut_q <= '0;
      rtsReq_q <= 1'b0;
      spareReq_q <= 1'b0;
      mpduDone_q <= 1'b0;
      mpduPrio_q <= 3'h0;
      idx_q <= 16'h0000;
      cnt_q <= 2'h0;
      crc_q <= CRC_INIT;
      chg_q <= 1'b0;
      meta_q <= '0;
      firstOut_q <= 1'b0;
      spareRem_q <= 19'h00000;
      padMore_q <= 1'b0;
    end else begin
      txOut_q <= '0;
      rtsReq_q <= 1'b0;
      spareReq_q <= 1'b0;
      mpduDone_q <= 1'b0;
      case (txState_q)
        T_IDLE: begin
          idx_q <= 16'h0000;
          crc_q <= CRC_INIT;
          padMore_q <= 1'b0;
          if (lpduValid) begin
            firstOut_q <= 1'b1;
            if (lpduMeta.needRts || ctrl_q[CTRL_RTS]) begin
              rtsReq_q <= 1'b1;
              txState_q <= T_CTS;
            end else begin
              txState_q <= T_BODY;
              lpduReady_q <= 1'b1;
            end
          end
        end
        T_CTS: begin
          if (ctsOk) begin
            txState_q <= T_BODY;
            lpduReady_q <= 1'b1;
          end
        end
        T_BODY: begin
          if (accept) begin
            idx_q <= idx_q + 16'h0001;
            if (idx_q == 16'h0000) begin
              meta_q <= lpduMeta;
              chg_q <= 1'b0;
            end
            if (idx_q == FLAG_OCTET && meta_q.resent) begin
              chg_q <= meta_q.newOpsf != lpduData[OPSF_BIT];
            end
            // Octets leave in arrival order, header octet 0 first
            if (idx_q >= HDR_LEN) begin
              txOut_q <= '{valid: 1'b1, data: dly_q[3], first: firstOut_q, last: 1'b0};
              firstOut_q <= 1'b0;
              crc_q <= crcByte(crc_q, dly_q[3], LPCS_POLY);
            end
            if (lpduLast) begin
              lpduReady_q <= 1'b0;
              cnt_q <= 2'h0;
              txState_q <= meta_q.lastInMpdu ? T_SPARE : T_FLUSH;
              spareReq_q <= meta_q.lastInMpdu;
            end
          end
        end
        T_SPARE: begin
          // Wait for the PHY to report the unused bits of the last symbol
          if (spareValid) begin
            spareRem_q <= {3'b000, spareBits};
            padMore_q <= {3'b000, spareBits} > lpduBits;
            txState_q <= T_FLUSH;
          end
        end
        T_FLUSH: begin
          // Original LPCS unless the OPSF bit moved
          txOut_q <= '{valid: 1'b1, data: chg_q ? crcOut[8*cnt_q +: 8] : dly_q[3], first: 1'b0,
                       last: cnt_q == 2'h3 && meta_q.lastInMpdu && !padMore_q};
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == 2'h3) begin
            idx_q <= 16'h0000;
            crc_q <= CRC_INIT;
            if (!meta_q.lastInMpdu) begin
              txState_q <= T_BODY;
              lpduReady_q <= 1'b1;
            end else if (padMore_q) begin
              spareRem_q <= spareRem_q - lpduBits;
              txState_q <= T_PAD;
            end else begin
              mpduDone_q <= 1'b1;
              mpduPrio_q <= prioCalc;
              txState_q <= T_IDLE;
            end
          end
        end
        T_PAD: begin
          // All-zero header keeps the valid flag clear; segment is zero
          idx_q <= idx_q + 16'h0001;
          if (idx_q < lpduLen_q - CRC_LEN) begin
            txOut_q <= '{valid: 1'b1, data: 8'h00, first: 1'b0, last: 1'b0};
            crc_q <= crcByte(crc_q, 8'h00, LPCS_POLY);
          end else begin
            txOut_q <= '{valid: 1'b1, data: crcOut[8*idx_q[1:0] +: 8], first: 1'b0,
                         last: idx_q == lpduLen_q - 16'h0001 && spareRem_q <= lpduBits};
          end
          if (idx_q == lpduLen_q - 16'h0001) begin
            idx_q <= 16'h0000;
            crc_q <= CRC_INIT;
            if (spareRem_q > lpduBits) begin
              spareRem_q <= spareRem_q - lpduBits;
            end else begin
              mpduDone_q <= 1'b1;
              mpduPrio_q <= prioCalc;
              txState_q <= T_IDLE;
            end
          end
        end
        default: txState_q <= T_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority: entry 0 tracks first-time data LPDUs, entry 1 resent ones
  logic [1:0] accSeen_q, accExcl_q, accAllTrail_q;
  logic [2:0] accMinAll_q [2];
  logic [2:0] accMinIncl_q [2];
  logic [2:0] accRes [2];

  for (genvar k = 0; k < 2; k++) begin : gAcc
    logic hitK;
    assign hitK = firstAcc && !lpduMeta.mgmt && lpduMeta.resent == (k == 1);
    assign accRes[k] = accAllTrail_q[k] ? accMinAll_q[k] : accMinIncl_q[k];
    // A leading trailing LPDU and the trailing ones after it are left out, unless every LPDU of the entry is trailing
    always_ff @(posedge clk) begin
      if (!rst_n || mpduStart) begin
        accSeen_q[k] <= 1'b0;
        accExcl_q[k] <= 1'b0;
        accAllTrail_q[k] <= 1'b0;
        accMinAll_q[k] <= MGMT_PRIO;
        accMinIncl_q[k] <= MGMT_PRIO;
      end else if (hitK) begin
        accSeen_q[k] <= 1'b1;
        accExcl_q[k] <= (accSeen_q[k] ? accExcl_q[k] : 1'b1) & lpduMeta.trailing;
        accAllTrail_q[k] <= (accSeen_q[k] ? accAllTrail_q[k] : 1'b1) & lpduMeta.trailing;
        if (!accSeen_q[k] || lpduMeta.lpri < accMinAll_q[k]) begin
          accMinAll_q[k] <= lpduMeta.lpri;
        end
        if (!((accSeen_q[k] ? accExcl_q[k] : 1'b1) && lpduMeta.trailing) && lpduMeta.lpri < accMinIncl_q[k]) begin
          accMinIncl_q[k] <= lpduMeta.lpri;
        end
      end
    end
  end

  // Management only gives 7; first-time data outranks resent data
  assign prioCalc = !(accSeen_q[0] || accSeen_q[1]) ? MGMT_PRIO : accSeen_q[0] ? accRes[0] : accRes[1];

  ////////////////////////////////////////////////////////////////////////////
  // Group order and SSN checks
  logic mgmtSeen_q, dataSeen_q, prevMgmt_q, anySeen_q, inGroup_q;
  logic [7:0] ssnLo_q;
  logic [15:0] prevSsn_q, ssnNow, ssnDiff;
  logic newGroup;

  assign newGroup = !(anySeen_q && lpduMeta.mgmt == prevMgmt_q);
  assign ssnNow = {lpduData, ssnLo_q};
  assign ssnDiff = ssnNow - prevSsn_q; // Modulo 2^16, so wrap compares correctly
  assign errSet[ERR_ORDER] = firstAcc && newGroup &&
                             (lpduMeta.mgmt ? (mgmtSeen_q || dataSeen_q) : dataSeen_q);
  assign errSet[ERR_SSN] = accept && idx_q == SSN_HI_OCTET && inGroup_q && ssnDiff[15];

  always_ff @(posedge clk) begin
    if (!rst_n || mpduStart) begin
      mgmtSeen_q <= 1'b0;
      dataSeen_q <= 1'b0;
      prevMgmt_q <= 1'b0;
      anySeen_q <= 1'b0;
      inGroup_q <= 1'b0;
      ssnLo_q <= 8'h00;
      prevSsn_q <= 16'h0000;
    end else if (accept) begin
      if (idx_q == 16'h0000) begin
        anySeen_q <= 1'b1;
        prevMgmt_q <= lpduMeta.mgmt;
        inGroup_q <= !newGroup;
        ssnLo_q <= lpduData;
        if (lpduMeta.mgmt) begin
          mgmtSeen_q <= 1'b1;
        end else begin
          dataSeen_q <= 1'b1;
        end
      end
      if (idx_q == SSN_HI_OCTET) begin
        prevSsn_q <= ssnNow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management LCDU formatter
  logic [10:0] lcCnt_q;
  logic [31:0] fcs_q;
  logic payReady_q;
  byte_beat_t lcduOut_q;
  logic [7:0] hdrByte;
  logic [47:0] dstAddr, srcAddr;
  logic [3:0] srcIdx;
  logic payAcc;
  logic [10:0] lcNext, fcsOut8;

  assign dstAddr = {daHi_q, daLo_q};
  assign srcAddr = {saHi_q, saLo_q};
  assign srcIdx = lcCnt_q[3:0] - LC_ADDR_LEN[3:0];
  assign payAcc = payValid && payReady_q;
  assign lcNext = lcCnt_q + 11'h001;
  assign fcsOut8 = 11'h000;

  // Destination first, then source, then the fixed type
  always_comb begin
    if (lcCnt_q < LC_ADDR_LEN) begin
      hdrByte = dstAddr[8*lcCnt_q[2:0] +: 8];
    end else if (lcCnt_q < LC_HDR_LEN - 11'h002) begin
      hdrByte = srcAddr[8*srcIdx[2:0] +: 8];
    end else if (lcCnt_q == LC_HDR_LEN - 11'h002) begin
      hdrByte = ETH_TYPE[15:8];
    end else begin
      hdrByte = ETH_TYPE[7:0];
    end
  end

  assign errSet[ERR_LEN] = payAcc && payLast &&
                           (lcNext < LC_HDR_LEN + LC_PAY_MIN || lcNext > LC_HDR_LEN + LC_PAY_MAX);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lcState_q <= L_IDLE;
      lcCnt_q <= 11'h000;
      fcs_q <= CRC_INIT;
      payReady_q <= 1'b0;
      lcduOut_q <= '0;
    end else begin
      lcduOut_q <= '0;
      case (lcState_q)
        L_IDLE: begin
          lcCnt_q <= 11'h000;
          fcs_q <= CRC_INIT;
          if (payValid) begin
            lcState_q <= L_HDR;
          end
        end
        L_HDR: begin
          lcduOut_q <= '{valid: 1'b1, data: hdrByte, first: lcCnt_q == 11'h000, last: 1'b0};
          fcs_q <= crcByte(fcs_q, hdrByte, FCS_POLY);
          lcCnt_q <= lcNext;
          if (lcNext == LC_HDR_LEN) begin
            lcState_q <= L_PAY;
            payReady_q <= 1'b1;
          end
        end
        L_PAY: begin
          if (payAcc) begin
            lcCnt_q <= lcNext;
            fcs_q <= crcByte(fcs_q, payData, FCS_POLY);
            lcduOut_q <= '{valid: 1'b1, data: payData, first: 1'b0,
                           last: payLast && lcNext >= LC_PAD_END && ctrl_q[CTRL_MIC]};
            if (payLast) begin
              payReady_q <= 1'b0;
              if (lcNext < LC_PAD_END) begin
                lcState_q <= L_PAD;
              end else if (ctrl_q[CTRL_MIC]) begin
                lcState_q <= L_IDLE;
              end else begin
                lcCnt_q <= fcsOut8;
                lcState_q <= L_FCS;
              end
            end
          end
        end
        L_PAD: begin
          // Zero octets up to 60, so the frame reaches 64 with its FCS
          lcduOut_q <= '{valid: 1'b1, data: 8'h00, first: 1'b0,
                         last: lcNext == LC_PAD_END && ctrl_q[CTRL_MIC]};
          fcs_q <= crcByte(fcs_q, 8'h00, FCS_POLY);
          lcCnt_q <= lcNext;
          if (lcNext == LC_PAD_END) begin
            lcCnt_q <= fcsOut8;
            lcState_q <= ctrl_q[CTRL_MIC] ? L_IDLE : L_FCS;
          end
        end
        L_FCS: begin
          lcduOut_q <= '{valid: 1'b1, data: ~fcs_q[8*lcCnt_q[1:0] +: 8], first: 1'b0,
                         last: lcNext == FCS_LEN};
          lcCnt_q <= lcNext;
          if (lcNext == FCS_LEN) begin
            lcState_q <= L_IDLE;
          end
        end
        default: lcState_q <= L_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive split: the MPDU is cut every LPDU length; padding LPDUs pass too
  logic [15:0] rxIdx_q;
  byte_beat_t rxLpdu_q;
  logic rxEnd;

  assign rxEnd = rxLast || rxIdx_q == lpduLen_q - 16'h0001;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxIdx_q <= 16'h0000;
      rxLpdu_q <= '0;
    end else begin
      rxLpdu_q <= '0;
      if (rxValid) begin
        rxLpdu_q <= '{valid: 1'b1, data: rxData, first: rxIdx_q == 16'h0000, last: rxEnd};
        rxIdx_q <= rxEnd ? 16'h0000 : rxIdx_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lpduReady = lpduReady_q;
  assign txOut = txOut_q;
  assign mpduPrio = mpduPrio_q;
  assign mpduDone = mpduDone_q;
  assign spareReq = spareReq_q;
  assign rtsReq = rtsReq_q;
  assign payReady = payReady_q;
  assign lcduOut = lcduOut_q;
  assign rxLpdu = rxLpdu_q;

endmodule

// [verilog/mpdu_pkg.sv]
// Constants, register map and carrier types of the MPDU assembler
package mpdu_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_DA_LO = 8'h08;
  localparam logic [7:0] REG_DA_HI = 8'h0C;
  localparam logic [7:0] REG_SA_LO = 8'h10;
  localparam logic [7:0] REG_SA_HI = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] REG_PRIO = 8'h1C;

  // Field positions
  localparam int CTRL_MIC = 0;
  localparam int CTRL_RTS = 1;
  localparam int ERR_ORDER = 0;
  localparam int ERR_SSN = 1;
  localparam int ERR_LEN = 2;
  localparam int STAT_TXBUSY = 8;
  localparam int STAT_LCBUSY = 9;
  localparam int OPSF_BIT = 4;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] LPDU_LEN_RST = 16'h0048;

  // LPDU layout, in octets
  localparam logic [15:0] HDR_LEN = 16'h0004;
  localparam logic [15:0] CRC_LEN = 16'h0004;
  localparam logic [15:0] FLAG_OCTET = 16'h0003;
  localparam logic [15:0] SSN_HI_OCTET = 16'h0001;
  localparam logic [2:0] MGMT_PRIO = 3'h7;

  // Management LCDU layout, in octets
  localparam logic [15:0] ETH_TYPE = 16'h22E3;
  localparam logic [10:0] LC_ADDR_LEN = 11'h006;
  localparam logic [10:0] LC_HDR_LEN = 11'h00E;
  localparam logic [10:0] LC_PAY_MIN = 11'h006;
  localparam logic [10:0] LC_PAY_MAX = 11'h5DC;
  localparam logic [10:0] LC_MIN_LEN = 11'h040;
  localparam logic [10:0] FCS_LEN = 11'h004;
  localparam logic [10:0] LC_PAD_END = LC_MIN_LEN - FCS_LEN;

  // Reflected CRC polynomials, LSB first
  localparam logic [31:0] LPCS_POLY = 32'h82F63B78;
  localparam logic [31:0] FCS_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  typedef struct packed {
    logic needRts;
    logic mgmt;
    logic resent;
    logic trailing;
    logic [2:0] lpri;
    logic newOpsf;
    logic lastInMpdu;
  } lpdu_meta_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic first;
    logic last;
  } byte_beat_t;

endpackage
